//--- wg_pkg.sv
// Constants, types and register map of the web guide I/O logic.
// Assumes one 40 MHz clock; positions are signed hundredths of a mm.
package wg_pkg;

    //////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned AXI_AW = 8;  // Byte address width
    localparam int unsigned AXI_DW = 32; // Data width

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_REF_OFS   = 8'h04;
    localparam logic [7:0] OFF_TOL       = 8'h08;
    localparam logic [7:0] OFF_RELAY_SEL = 8'h0C;
    localparam logic [7:0] OFF_INPUT_SEL = 8'h10;
    localparam logic [7:0] OFF_STATUS    = 8'h14;
    localparam logic [7:0] OFF_REF_ACT   = 8'h18;
    localparam logic [7:0] OFF_DEV       = 8'h1C;

    // Control field positions
    localparam int unsigned CTRL_REF_AUTO_BIT  = 0;
    localparam int unsigned CTRL_RETENTION_BIT = 1;
    localparam int unsigned CTRL_LEAVE_CTR_BIT = 2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    //////////////////////////////////////////////////////////////////////
    // Limits and reset values
    localparam logic signed [15:0] REF_MAX   = 16'sh01F4; // +5.00 mm
    localparam logic signed [15:0] REF_MIN   = -16'sh01F4; // -5.00 mm
    localparam logic signed [15:0] REF_TOP   = 16'sh7FFF; // Step ceiling
    localparam logic signed [15:0] REF_BOT   = -16'sh7FFF; // Step floor
    localparam logic signed [15:0] REF_RST   = 16'sh0000; // 0.00 mm
    localparam logic [4:0]  TOL_MAX          = 5'h14;     // 2.0 mm
    localparam logic [4:0]  TOL_RST          = 5'h01;     // 0.1 mm
    localparam logic [6:0]  TOL_SCALE        = 7'h0A;     // 0.1 mm / 0.01
    localparam logic [2:0]  CTRL_RST         = 3'h0;
    localparam logic [7:0]  RELAY_SEL_RST    = 8'h21;
    localparam logic [31:0] INPUT_SEL_RST    = 32'h7777_4320;

    //////////////////////////////////////////////////////////////////////
    // Relay functions
    typedef enum logic [2:0] {
        WG_RLY_DISABLED,
        WG_RELAY_SENSOR_MIDDLE,
        WG_RELAY_MATERIAL_PRESENT,
        WG_RLY_AUTO_MATERIAL,
        WG_RLY_AUTO_MISSING,
        WG_RLY_AUTOMATIC,
        WG_RLY_CENTRED
    } wg_relay_fn_t;

    // Digital input functions
    typedef enum logic [2:0] {
        WG_IN_EDGE_MODE,
        WG_INPUT_LEVEL_MODE,
        WG_IN_CENTRE,
        WG_IN_DECREASE,
        WG_IN_INCREASE,
        WG_IN_LOCK,
        WG_INPUT_REFERENCE_CLEAR,
        WG_IN_DISABLED
    } wg_in_fn_t;

    // Sensor report
    typedef struct packed {
        logic               material;   // Edge detected
        logic               at_middle;  // Edge at sensor middle
        logic signed [15:0] edge_pos;   // Edge position
    } wg_sensor_t;

    // Motor drive command
    typedef struct packed {
        logic move_left;   // Retract
        logic move_right;  // Extend
        logic centre_run;  // Run to centre
        logic hold;        // Stand still
    } wg_drive_t;

endpackage

//--- wg_io_logic.sv
// Web guide I/O logic: reference, tolerance window, relays, inputs.
// Assumes an AXI4-Lite master, asynchronous input pins, and sensor and
// drive status produced on aclk.
//
// How it works
// R1 - manual offset -5.00..+5.00 mm, default 0
// R2 - manual source uses stored offset
// R3 - automatic source captures edge on entering automatic
// R4 - retention off: restart clears reference
// R5 - retention on: restart keeps reference
// R6 - software must not combine capture and retention
// R7 - no correction inside tolerance window
// R8 - sensor middle relay follows middle flag
// R9 - material present relay follows detection
// R10 - automatic and material relay
// R11 - automatic and missing relay
// R12 - automatic relay follows automatic
// R13 - centred relay after centre run standstill
// R14 - disabled relay never energised
// R15 - edge input toggles automatic mode
// R16 - level input sets automatic mode
// R17 - centre input edge starts centre run
// R18 - decrease input jogs left or decrements
// R19 - increase input jogs right or increments
// R20 - lock input holds drive still; a centre run continues under lock when the leave-to-centre control bit is set
// R21 - lock, mode, leave setting resolve drive
// R22 - clear input zeroes reference on edge
// R23 - inputs synchronised, one action per edge
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module wg_io_logic #(
    parameter int unsigned NUM_IN = 4  // Digital inputs in use
) (
    // Clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite write channels
    input  wire logic [wg_pkg::AXI_AW-1:0]     s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [wg_pkg::AXI_DW-1:0]     s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [wg_pkg::AXI_AW-1:0]     s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [wg_pkg::AXI_DW-1:0]          s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Machine side
    input  wire logic [NUM_IN-1:0]             din_pin,
    input  wire logic                          restart_req,
    input  wire wg_pkg::wg_sensor_t            sensor,
    input  wire logic                          drive_standstill,
    input  wire logic                          drive_at_centre,
    output var  wg_pkg::wg_drive_t             drive_cmd,
    output logic [1:0]                         relay_out
);
    import wg_pkg::*;

    if (NUM_IN < 1 || NUM_IN > 8)
    begin : g_chk
        $error("NUM_IN must be 1 to 8");
    end

    //////////////////////////////////////////////////////////////////////
    // Functions

    // Byte-lane merge of a write into a word
    function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                m[8*b +: 8] = dat[8*b +: 8];
        return m;
    endfunction

    // Relay level for one selection
    function automatic logic relay_fn(input logic [2:0] sel,
                                      input logic auto, mat, mid, ctd);
        case (wg_relay_fn_t'(sel))
            WG_RELAY_SENSOR_MIDDLE:    relay_fn = mid;        // [R8]
            WG_RELAY_MATERIAL_PRESENT: relay_fn = mat;        // [R9]
            WG_RLY_AUTO_MATERIAL:      relay_fn = auto & mat;  // [R10]
            WG_RLY_AUTO_MISSING:       relay_fn = auto & ~mat; // [R11]
            WG_RLY_AUTOMATIC:          relay_fn = auto;       // [R12]
            WG_RLY_CENTRED:            relay_fn = ctd;        // [R13]
            default:                   relay_fn = 1'b0;
        endcase
    endfunction

    // Magnitude of a 17-bit deviation
    function automatic logic [16:0] mag(input logic signed [16:0] v);
        return v[16] ? 17'(-v) : 17'(v);
    endfunction

    //////////////////////////////////////////////////////////////////////
    // State
    logic [NUM_IN-1:0]  din_meta_r;            // First sync stage only
    logic [NUM_IN-1:0]  din_sync_r, din_prev_r;
    logic [NUM_IN-1:0]  din_rise;              // One pulse per rising edge
    logic               auto_r, auto_nxt;      // Automatic operation
    logic               centring_r, centring_nxt;
    logic               centred_r, centred_nxt;
    logic signed [15:0] ref_r, ref_nxt;        // Active reference
    logic signed [15:0] ofs_r, ofs_nxt;        // Manual offset
    logic [4:0]         tol_r, tol_nxt;        // Window, 0.1 mm units
    logic [2:0]         ctrl_r, ctrl_nxt;
    logic [7:0]         rsel_r, rsel_nxt;
    logic [31:0]        isel_r, isel_nxt;
    wg_drive_t          drive_nxt;
    logic [1:0]         relay_nxt;
    // Bus state
    logic               awh_r, awh_nxt, wh_r, wh_nxt;
    logic [7:0]         awa_r, awa_nxt;
    logic [31:0]        wd_r, wd_nxt;
    logic [3:0]         ws_r, ws_nxt;
    logic               bv_r, bv_nxt, rv_r, rv_nxt;
    logic [1:0]         br_r, br_nxt, rr_r, rr_nxt;
    logic [31:0]        rd_r, rd_nxt;
    // Combinational helpers
    logic               lock_any, clr_any, inc_any, dec_any, ctr_go;
    logic               jog_l, jog_r, guide, do_wr, aw_have, w_have;
    logic [7:0]         wa;
    logic [31:0]        wdat, wm;
    logic signed [15:0] wofs;
    logic signed [16:0] dev;
    logic [16:0]        tol_h;

    assign din_rise = din_sync_r & ~din_prev_r;  // [R23]
    assign dev      = 17'(sensor.edge_pos) - 17'(ref_r);
    assign tol_h    = 17'(tol_r * TOL_SCALE);

    // Handshake outputs
    assign s_axi_awready = ~awh_r & ~bv_r;
    assign s_axi_wready  = ~wh_r & ~bv_r;
    assign s_axi_arready = ~rv_r;
    assign s_axi_bvalid  = bv_r;
    assign s_axi_bresp   = br_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rresp   = rr_r;
    assign s_axi_rdata   = rd_r;

    //////////////////////////////////////////////////////////////////////
    // Next-state logic for bus, reference, mode and outputs
    always_comb
    begin
        auto_nxt = auto_r;
        centring_nxt = centring_r;
        centred_nxt = centred_r;
        ref_nxt = ref_r;
        ofs_nxt = ofs_r;
        tol_nxt = tol_r;
        ctrl_nxt = ctrl_r;
        rsel_nxt = rsel_r;
        isel_nxt = isel_r;
        lock_any = 1'b0;
        clr_any = 1'b0;
        inc_any = 1'b0;
        dec_any = 1'b0;
        ctr_go = 1'b0;
        jog_l = 1'b0;
        jog_r = 1'b0;
        // Input decode; later inputs win on mode conflicts
        for (int i = 0; i < NUM_IN; i++)
        begin
            case (wg_in_fn_t'(isel_r[4*i +: 3]))
                WG_IN_EDGE_MODE:
                    if (din_rise[i])
                        auto_nxt = ~auto_nxt;         // [R15]
                WG_INPUT_LEVEL_MODE:
                    auto_nxt = din_sync_r[i];         // [R16]
                WG_IN_CENTRE:
                    ctr_go = ctr_go | din_rise[i];    // [R17]
                WG_IN_DECREASE:
                begin
                    jog_l = jog_l | din_sync_r[i];    // [R18]
                    dec_any = dec_any | din_rise[i];
                end
                WG_IN_INCREASE:
                begin
                    jog_r = jog_r | din_sync_r[i];    // [R19]
                    inc_any = inc_any | din_rise[i];
                end
                WG_IN_LOCK:
                    lock_any = lock_any | din_sync_r[i];
                WG_INPUT_REFERENCE_CLEAR:
                    clr_any = clr_any | din_rise[i];
                default:
                    ;
            endcase
        end
        // Reference stepping only in automatic
        if (auto_r && inc_any && !dec_any && ref_r != REF_TOP)
            ref_nxt = ref_r + 16'sh0001;              // [R19]
        if (auto_r && dec_any && !inc_any && ref_r != REF_BOT)
            ref_nxt = ref_r - 16'sh0001;              // [R18]

        // Bus write path: address and data in either order
        aw_have = awh_r | s_axi_awvalid;
        w_have = wh_r | s_axi_wvalid;
        wa = awh_r ? awa_r : s_axi_awaddr;
        wdat = wh_r ? wd_r : s_axi_wdata;
        do_wr = aw_have & w_have & ~bv_r;
        awh_nxt = awh_r | (s_axi_awvalid & s_axi_awready);
        awa_nxt = awh_r ? awa_r : s_axi_awaddr;
        wh_nxt = wh_r | (s_axi_wvalid & s_axi_wready);
        wd_nxt = wdat;
        ws_nxt = wh_r ? ws_r : s_axi_wstrb;
        bv_nxt = bv_r & ~s_axi_bready;
        br_nxt = br_r;
        wm = 32'h0000_0000;
        wofs = REF_RST;
        if (do_wr)
        begin
            awh_nxt = 1'b0;
            wh_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = RESP_OKAY;
            case (wa)
                OFF_CTRL:
                begin
                    wm = wr_merge(32'(ctrl_r), wdat, ws_nxt);
                    ctrl_nxt = wm[2:0];
                end
                OFF_REF_OFS:
                begin
                    wm = wr_merge(32'(ofs_r), wdat, ws_nxt);
                    wofs = wm[15:0];
                    // Out-of-range writes saturate to the limits
                    if (wofs > REF_MAX)
                        wofs = REF_MAX;                // [R1]
                    else if (wofs < REF_MIN)
                        wofs = REF_MIN;                // [R1]
                    ofs_nxt = wofs;
                    if (!ctrl_r[CTRL_REF_AUTO_BIT])
                        ref_nxt = wofs;                // [R2]
                end
                OFF_TOL:
                begin
                    wm = wr_merge(32'(tol_r), wdat, ws_nxt);
                    tol_nxt = (wm[7:0] > 8'(TOL_MAX)) ? TOL_MAX : wm[4:0];
                end
                OFF_RELAY_SEL:
                begin
                    wm = wr_merge(32'(rsel_r), wdat, ws_nxt);
                    rsel_nxt = wm[7:0];
                end
                OFF_INPUT_SEL:
                    isel_nxt = wr_merge(isel_r, wdat, ws_nxt);
                default:
                    br_nxt = RESP_DECERR;
            endcase
        end
        // Clear wins over a bus write in the same cycle
        if (clr_any)
        begin
            ref_nxt = REF_RST;                         // [R22]
            ofs_nxt = REF_RST;
        end

        // Mode transitions
        if (auto_nxt && !auto_r)
        begin
            centring_nxt = 1'b0;
            if (ctrl_r[CTRL_REF_AUTO_BIT])
                ref_nxt = sensor.edge_pos;             // [R3]
            else
                ref_nxt = ofs_r;                       // [R2]
        end
        // Leaving automatic to centre ignores the lock
        if (!auto_nxt && auto_r && ctrl_r[CTRL_LEAVE_CTR_BIT])
            centring_nxt = 1'b1;                       // [R21]
        if (!auto_nxt && ctr_go)
            centring_nxt = 1'b1;                       // [R17]

        // Drive resolution
        guide = auto_r & ~lock_any & sensor.material & (mag(dev) > tol_h);
        drive_nxt.move_left = (guide & ~dev[16]) |    // [R7]
            (~auto_r & ~lock_any & ~centring_r & jog_l & ~jog_r); // [R20]
        drive_nxt.move_right = (guide & dev[16]) |    // [R7]
            (~auto_r & ~lock_any & ~centring_r & jog_r & ~jog_l); // [R20]
        // Lock parks a centre run unless the leave-to-centre control bit is set
        drive_nxt.centre_run = ~auto_r & centring_r &  // [R21]
            ~(lock_any & ~ctrl_r[CTRL_LEAVE_CTR_BIT]);
        drive_nxt.hold = ~drive_nxt.move_left & ~drive_nxt.move_right &
                         ~drive_nxt.centre_run;       // [R21]
        // Any other move drops the centred flag; arrival sets it
        if (drive_nxt.move_left || drive_nxt.move_right || auto_nxt)
            centred_nxt = 1'b0;
        if (centring_r && drive_standstill && drive_at_centre)
        begin
            centring_nxt = 1'b0;
            centred_nxt = 1'b1;                        // [R13]
        end

        // Restart: manual operation, reference per retention
        if (restart_req)
        begin
            auto_nxt = 1'b0;
            centring_nxt = 1'b0;
            centred_nxt = 1'b0;
            if (ctrl_r[CTRL_RETENTION_BIT])
            begin
                ref_nxt = ref_r;                       // [R5]
                ofs_nxt = ofs_r;
            end
            else
            begin
                ref_nxt = REF_RST;                     // [R4]
                ofs_nxt = REF_RST;
            end
        end

        // Relays from registered status
        for (int k = 0; k < 2; k++)
            relay_nxt[k] = relay_fn(rsel_r[4*k +: 3], auto_r,  // [R8]
                                    sensor.material, sensor.at_middle,
                                    centred_r);                // [R14]

        // Bus read path, answered one cycle after the address
        rv_nxt = rv_r & ~s_axi_rready;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        if (s_axi_arvalid && !rv_r)
        begin
            rv_nxt = 1'b1;
            rr_nxt = RESP_OKAY;
            case (s_axi_araddr)
                OFF_CTRL:      rd_nxt = 32'(ctrl_r);
                OFF_REF_OFS:   rd_nxt = 32'(ofs_r);
                OFF_TOL:       rd_nxt = 32'(tol_r);
                OFF_RELAY_SEL: rd_nxt = 32'(rsel_r);
                OFF_INPUT_SEL: rd_nxt = isel_r;
                OFF_STATUS:    rd_nxt = 32'({relay_out, 3'h0, sensor.material,
                                  centred_r, centring_r, lock_any, auto_r});
                OFF_REF_ACT:   rd_nxt = 32'(ref_r);
                OFF_DEV:       rd_nxt = 32'(dev);
                default:
                begin
                    rd_nxt = 32'h0000_0000;
                    rr_nxt = RESP_DECERR;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Registers; pins pass two stages before use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            din_meta_r <= '0;
            din_sync_r <= '0;
            din_prev_r <= '0;
            auto_r <= 1'b0;
            centring_r <= 1'b0;
            centred_r <= 1'b0;
            ref_r <= REF_RST;
            ofs_r <= REF_RST;
            tol_r <= TOL_RST;
            ctrl_r <= CTRL_RST;
            rsel_r <= RELAY_SEL_RST;
            isel_r <= INPUT_SEL_RST;
            drive_cmd <= 4'h1;
            relay_out <= 2'h0;
            awh_r <= 1'b0;
            awa_r <= 8'h00;
            wh_r <= 1'b0;
            wd_r <= 32'h0000_0000;
            ws_r <= 4'h0;
            bv_r <= 1'b0;
            br_r <= RESP_OKAY;
            rv_r <= 1'b0;
            rr_r <= RESP_OKAY;
            rd_r <= 32'h0000_0000;
        end
        else
        begin
            din_meta_r <= din_pin;                     // [R23]
            din_sync_r <= din_meta_r;
            din_prev_r <= din_sync_r;
            auto_r <= auto_nxt;
            centring_r <= centring_nxt;
            centred_r <= centred_nxt;
            ref_r <= ref_nxt;
            ofs_r <= ofs_nxt;
            tol_r <= tol_nxt;
            ctrl_r <= ctrl_nxt;
            rsel_r <= rsel_nxt;
            isel_r <= isel_nxt;
            drive_cmd <= drive_nxt;
            relay_out <= relay_nxt;
            awh_r <= awh_nxt;
            awa_r <= awa_nxt;
            wh_r <= wh_nxt;
            wd_r <= wd_nxt;
            ws_r <= ws_nxt;
            bv_r <= bv_nxt;
            br_r <= br_nxt;
            rv_r <= rv_nxt;
            rr_r <= rr_nxt;
            rd_r <= rd_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Checks, all on aclk and quiet during reset
    default clocking chk_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_OFS_RANGE: assert property ( // [R1]
        ofs_r <= REF_MAX && ofs_r >= REF_MIN)
        else $error("offset out of range");
    AST_MAN_REF: assert property ( // [R2]
        (auto_nxt && !auto_r && !ctrl_r[0]) |=> ref_r == $past(ofs_r))
        else $error("manual reference not loaded");
    AST_CAPTURE: assert property ( // [R3]
        (auto_nxt && !auto_r && ctrl_r[0]) |=> ref_r == $past(sensor.edge_pos))
        else $error("edge not captured");
    AST_RST_CLR: assert property ( // [R4]
        (restart_req && !ctrl_r[1]) |=> (ref_r == 0 && ofs_r == 0 && !auto_r))
        else $error("restart did not clear");
    AST_RST_KEEP: assert property ( // [R5]
        (restart_req && ctrl_r[1]) |=> $stable(ref_r))
        else $error("restart lost reference");
    AST_WINDOW: assert property ( // [R7]
        (auto_r && mag(dev) <= tol_h) |=>
        !drive_cmd.move_left && !drive_cmd.move_right)
        else $error("correction inside window");
    AST_RLY_OFF: assert property ( // [R14]
        (rsel_r[2:0] == 3'h0) |=> !relay_out[0])
        else $error("disabled relay on");
    AST_LOCK_MAN: assert property ( // [R20]
        (!auto_r && lock_any && !(centring_r && ctrl_r[2])) |=>
        drive_cmd.hold)
        else $error("locked drive moved");
    AST_LOCK_AUTO: assert property ( // [R21]
        (auto_r && lock_any) |=> drive_cmd.hold)
        else $error("lock ignored in automatic");
    AST_REF_CLR: assert property ( // [R22]
        (clr_any && !restart_req && !(auto_nxt && !auto_r)) |=> ref_r == 0)
        else $error("reference clear missed");

endmodule

`default_nettype wire

//--- wg_drv_model.sv
// Motor drive stand-in for the web guide I/O logic.
// Assumes drive_cmd is registered on aclk.
`timescale 1ns/100ps
`default_nettype none
module wg_drv_model (
    // Clock and command
    input  wire logic              aclk,
    input  wire wg_pkg::wg_drive_t cmd,
    // Drive status
    output logic                   still,
    output logic                   at_ctr
);
    import wg_pkg::*;
    ////////////////////////////////////////////////////////////////////
    // Centre travel takes a few cycles, so the run is seen in motion
    logic [1:0] run_r = 2'h0;
    always_ff @(posedge aclk)
        run_r <= cmd.centre_run ? run_r + {1'b0, ~&run_r} : 2'h0;
    // Stands still when no jog and the centre run has arrived
    assign still = ~(cmd.move_left | cmd.move_right)
                 & ~(cmd.centre_run & ~&run_r);
    assign at_ctr = &run_r;
endmodule
`default_nettype wire

//--- wg_io_logic_tb_top.sv
// Directed tests of the web guide I/O logic over AXI4-Lite.
// Assumes the drive model answers the drive commands.
`timescale 1ns/100ps
`default_nettype none
module wg_io_logic_tb_top;
    import wg_pkg::*;
    logic aclk = 0, aresetn = 0, rst_req = 0, awv = 0, wv = 0, br = 0;
    logic arv = 0, rr = 0, awr, wry, bv, arr, rv, still, at_ctr;
    logic [7:0] aa = 0, ra = 0;
    logic [31:0] wd = 0, rdat;
    logic [1:0] bresp, rresp, relay_out;
    logic [3:0] din_pin = 0;
    wg_sensor_t sensor = '{1'b0, 1'b1, 16'sh0000};
    wg_drive_t drive_cmd;
    int error_cnt = 0, tests_run = 0;
    always #12.5 aclk = ~aclk;  // 40 MHz
    wg_io_logic i_wg_io_logic (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wry), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .din_pin(din_pin),
        .restart_req(rst_req), .sensor(sensor), .drive_standstill(still),
        .drive_at_centre(at_ctr), .drive_cmd(drive_cmd),
        .relay_out(relay_out));
    wg_drv_model i_wg_drv_model (.aclk(aclk), .cmd(drive_cmd),
        .still(still), .at_ctr(at_ctr));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Settle past the edge before looking at outputs
    task automatic step(int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        aa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        br <= 1;
        tb = 0;
        for (int n = 0; !tb; n++)
        begin
            if (n == 40)
                error_cnt++;
            if (n == 40)
                stop_test();
            @(negedge aclk);
            ta = awv & awr;
            tw = wv & wry;
            tb = bv;
            if (tb) chk("bresp", RESP_OKAY, bresp);
            @(posedge aclk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
            if (tb) br <= 0;
        end
    endtask
    task automatic rc(string nm, logic [7:0] a, logic [31:0] e,
                      logic [31:0] m = '1, logic [1:0] er = RESP_OKAY);
        logic ta, tr;
        @(posedge aclk);
        ra <= a;
        arv <= 1;
        rr <= 1;
        tr = 0;
        for (int n = 0; !tr; n++)
        begin
            if (n == 40)
                error_cnt++;
            if (n == 40)
                stop_test();
            @(negedge aclk);
            ta = arv & arr;
            tr = rv;
            if (tr) chk(nm, e, rdat & m);
            if (tr) chk("rresp", er, rresp);
            @(posedge aclk);
            if (ta) arv <= 0;
            if (tr) rr <= 0;
        end
    endtask
    task automatic pin(int i, logic v);
        @(posedge aclk);
        din_pin[i] <= v;
        step(6);
    endtask
    task automatic pulse(int i);
        pin(i, 1);
        pin(i, 0);
    endtask
    task automatic pos(logic signed [15:0] v);
        @(posedge aclk);
        sensor.edge_pos <= v;
        step(3);
    endtask
    task automatic reboot();
        @(posedge aclk);
        rst_req <= 1;
        @(posedge aclk);
        rst_req <= 0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        rc("insel", OFF_INPUT_SEL, 32'h7777_4320);
        rc("rlsel", OFF_RELAY_SEL, 32'h0000_0021);
        rc("tol", OFF_TOL, 32'h0000_0001);
        step(1);
        chk("relay", 32'h0000_0001, relay_out);
        @(posedge aclk);
        sensor.material <= 1;
        wr(OFF_REF_OFS, 32'h0000_0258);
        rc("ofs", OFF_REF_OFS, 32'h0000_01F4);
        chk("relay", 32'h0000_0003, relay_out);
        wr(OFF_REF_OFS, 32'hFFFF_FC18);
        rc("ofs", OFF_REF_OFS, 32'hFFFF_FE0C);
        rc("hole", 8'h20, 32'h0000_0000, '1, RESP_DECERR);
        $display("Test of settings done");
        wr(OFF_REF_OFS, 32'h0000_0064);
        wr(OFF_RELAY_SEL, 32'h0000_0043);
        step(1);
        chk("relay", 32'h0000_0000, relay_out);
        pulse(0);
        rc("auto", OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
        chk("relay", 32'h0000_0001, relay_out);
        rc("ref", OFF_REF_ACT, 32'h0000_0064);
        pos(16'sh006E);
        chk("band", 32'h0000_0000, drive_cmd[3:2]);
        pos(16'sh006F);
        chk("left", 32'h0000_0002, drive_cmd[3:2]);
        pos(16'sh0059);
        chk("right", 32'h0000_0001, drive_cmd[3:2]);
        wr(OFF_INPUT_SEL, 32'h7777_4350);
        pin(1, 1);
        chk("lock", 32'h0000_0001, drive_cmd);
        pin(1, 0);
        pulse(2);
        rc("ref", OFF_REF_ACT, 32'h0000_0063);
        pulse(3);
        rc("ref", OFF_REF_ACT, 32'h0000_0064);
        wr(OFF_INPUT_SEL, 32'h7777_6321);
        pulse(3);
        rc("ref", OFF_REF_ACT, 32'h0000_0000);
        rc("auto", OFF_STATUS, 32'h0000_0000, 32'h0000_0001);
        pin(0, 1);
        rc("auto", OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
        pin(0, 0);
        $display("Test of modes done");
        wr(OFF_RELAY_SEL, 32'h0000_0060);
        pulse(1);
        for (int n = 0; n < 40 && relay_out[1] !== 1'b1; n++)
            step(1);
        chk("centred", 32'h0000_0002, relay_out);
        wr(OFF_CTRL, 32'h0000_0005);
        pin(0, 1);
        rc("ref", OFF_REF_ACT, 32'h0000_0059);
        pin(0, 0);
        chk("leave", 32'h0000_0002, drive_cmd);
        wr(OFF_REF_OFS, 32'h0000_0032);
        reboot();
        rc("ofs", OFF_REF_OFS, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0002);
        wr(OFF_REF_OFS, 32'h0000_0032);
        reboot();
        rc("ofs", OFF_REF_OFS, 32'h0000_0032);
        rc("ref", OFF_REF_ACT, 32'h0000_0032);
        $display("Test of restart done");
        stop_test();
    end
endmodule
`default_nettype wire
